// ---- src/spb_cfg.svh ----
// How it works
// - shift mode rate is oscillator over 12
// - mode 2 rate oscillator over 64 or 32
// - timer1 overflow times doubling over 32
// - timer1 auto-reload rate from reload byte
// - clock selects put timer2 in generator mode
// - second port selects live in power control
// - high byte rollover reloads both count bytes
// - timer2 generator rate is overflow over 16
// - timer2 timer operation counts every state in generator mode
// - generator mode needs any clock select set
// - generator rollover never sets overflow flag
// - external edge sets flag, no reload in generator mode
// - shift mode data on rxd, clock on txd
// - buffer write arms send one cycle later
// - shift clock low S3-S5, shift at S6P2
// - marker detect, last shift, flag at S1P1
// - reception starts on enable with flag clear
// - receive clock toggles, samples at S5P2
// - last shift loads buffer, flag at S1P1
// - mode bits select shift or async mode
`ifndef SPB_CFG_SVH
`define SPB_CFG_SVH

// register byte offsets
`define SPB_OFF_SCTRL   8'h00
`define SPB_OFF_SERIAL_BUFFER    8'h04
`define SPB_OFF_PCTRL   8'h08
`define SPB_OFF_TMODE   8'h0C
`define SPB_OFF_TRUN    8'h10
`define SPB_OFF_T1CNT   8'h14
`define SPB_OFF_T2CTRL  8'h18
`define SPB_OFF_T2CNT   8'h1C
`define SPB_OFF_T2RLD   8'h20

// serial control fields
`define SPB_SC_SM0      7
`define SPB_SC_SM1      6
`define SPB_SC_REN      4
`define SPB_SC_TI       1
`define SPB_SC_RI       0
// power control fields
`define SPB_PC_DOUBLE   7
`define SPB_PC_P2TX     1
`define SPB_PC_P2RX     0
// timer1 nibble of timer mode register
`define SPB_TM_CT       6
`define SPB_TM_M1       5
`define SPB_TM_M0       4
`define SPB_TR_RUN1     0
// timer2 control fields
`define SPB_T2_TF       7
`define SPB_T2_EXF      6
`define SPB_T2_RCLK     5
`define SPB_T2_TX_CLOCK_SELECT     4
`define SPB_T2_EXEN     3
`define SPB_T2_RUN      2
`define SPB_T2_CT       1
`define SPB_T2_CAP      0

`define SPB_RST_BYTE    8'h00
`define SPB_RX_PRESET   8'hFE
`define SPB_TX_MARK     8'h01

// phase index within a machine cycle: S1P1 = 0 ... S6P2 = 11
`define SPB_PH_LAST     4'hB
`define SPB_PH_S1P1     4'h0
`define SPB_PH_S3P1     4'h4
`define SPB_PH_S5P2     4'h9
`define SPB_PH_S6P1     4'hA
`define SPB_PH_S6P2     4'hB
`define SPB_DIV_T1      5'h1F
`define SPB_DIV_T1_DBL  5'h0F
`define SPB_DIV_T2      4'hF
`define SPB_DIV_M2      6'h3F
`define SPB_DIV_M2_DBL  6'h1F

`endif

// ---- src/spb_pkg.sv ----
package spb_pkg;

    typedef enum logic [1:0] {
        SPB_TX_IDLE = 2'b00,
        SPB_TX_ARM  = 2'b01,
        SPB_TX_SEND = 2'b11,
        SPB_TX_LAST = 2'b10
    } spb_tx_e;

    typedef enum logic [1:0] {
        SPB_RX_IDLE = 2'b00,
        SPB_RX_ARM  = 2'b01,
        SPB_RX_RECV = 2'b11,
        SPB_RX_DONE = 2'b10
    } spb_rx_e;

    typedef struct packed {
        logic       wr;
        logic [7:0] off;
    } spb_ahb_ph_s;

    typedef struct packed {
        logic tx;
        logic rx;
    } spb_tick_s;

endpackage : spb_pkg

// ---- src/spb_serial_baud.sv ----
`timescale 1ns/1ps
`include "spb_cfg.svh"

module spb_serial_baud
    import spb_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // serial pins, port one
    input  wire logic        rxd_in,
    output logic             rxd_out,
    output logic             rxd_oe,
    output logic             txd_out,
    // timer pins
    input  wire logic        t1_pin,
    input  wire logic        t2_pin,
    input  wire logic        timer2_external_pin,
    // bit-rate ticks toward the frame logic, and the timer 2 interrupt flag
    output spb_tick_s        port1_tick,
    output spb_tick_s        port2_tick,
    output logic             timer2_irq_flag
);

    // ---------------- pin synchronisers
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    wire  [3:0] pin_raw = {timer2_external_pin, t2_pin, t1_pin, rxd_in};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1 <= 4'hF;
            pin_s2 <= 4'hF;
            pin_s3 <= 4'hF;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    wire rxd_sync  = pin_s2[0];
    wire t1_fall   = pin_s3[1] & ~pin_s2[1];
    wire t2_fall   = pin_s3[2] & ~pin_s2[2];
    wire timer2_external_pin_fall = pin_s3[3] & ~pin_s2[3];

    // ---------------- machine cycle phases
    logic [3:0] ph;
    wire        ph_wrap  = (ph == `SPB_PH_LAST);
    wire  [3:0] ph_nxt   = ph_wrap ? 4'h0 : ph + 4'h1;
    wire        mc_tick  = (ph == `SPB_PH_S6P2);
    wire        st_tick  = ph[0];
    wire        at_s1p1  = (ph == `SPB_PH_S1P1);
    wire        at_s5p2  = (ph == `SPB_PH_S5P2);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) ph <= 4'h0;
        else          ph <= ph_nxt;
    end

    // ---------------- bus slave
    spb_ahb_ph_s dp;
    wire         ap_valid = hsel & htrans[1] & hready;
    wire  [7:0]  ap_off   = haddr[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp        <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dp.wr     <= ap_valid & hwrite;
            dp.off    <= ap_off;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    wire wr_sctrl  = dp.wr & (dp.off == `SPB_OFF_SCTRL);
    wire wr_serial_buffer   = dp.wr & (dp.off == `SPB_OFF_SERIAL_BUFFER);
    wire wr_pctrl  = dp.wr & (dp.off == `SPB_OFF_PCTRL);
    wire wr_tmode  = dp.wr & (dp.off == `SPB_OFF_TMODE);
    wire wr_trun   = dp.wr & (dp.off == `SPB_OFF_TRUN);
    wire wr_t1cnt  = dp.wr & (dp.off == `SPB_OFF_T1CNT);
    wire wr_t2ctrl = dp.wr & (dp.off == `SPB_OFF_T2CTRL);
    wire wr_t2cnt  = dp.wr & (dp.off == `SPB_OFF_T2CNT);
    wire wr_t2rld  = dp.wr & (dp.off == `SPB_OFF_T2RLD);

    // ---------------- software registers
    logic [7:0]  serial_control_register;
    logic [7:0]  power_control_register;
    logic [7:0]  timer_mode_register;
    logic [7:0]  timer_run_register;
    logic [7:0]  timer2_control_register;
    logic [7:0]  serial_buffer;
    logic [7:0]  timer1_count_low;
    logic [7:0]  timer1_reload_byte;
    logic [7:0]  timer2_count_low;
    logic [7:0]  timer2_count_high;
    logic [7:0]  timer2_reload_low;
    logic [7:0]  timer2_reload_high;
    logic        transmit_flag;
    logic        receive_flag;
    logic        timer2_overflow_flag;
    logic        timer2_external_flag;

    wire mode_select_low  = serial_control_register[`SPB_SC_SM0];
    wire mode_select_high = serial_control_register[`SPB_SC_SM1];
    wire rx_enable        = serial_control_register[`SPB_SC_REN];
    wire rate_double_bit  = power_control_register[`SPB_PC_DOUBLE];
    wire port2_tx_clock_select  = power_control_register[`SPB_PC_P2TX];
    wire port2_rx_clock_select  = power_control_register[`SPB_PC_P2RX];
    wire rx_clock_select        = timer2_control_register[`SPB_T2_RCLK];
    wire tx_clock_select        = timer2_control_register[`SPB_T2_TX_CLOCK_SELECT];
    wire timer2_external_enable = timer2_control_register[`SPB_T2_EXEN];
    wire timer2_run_bit         = timer2_control_register[`SPB_T2_RUN];
    wire timer2_counter_select  = timer2_control_register[`SPB_T2_CT];
    wire timer2_capture_mode    = timer2_control_register[`SPB_T2_CAP];

    wire mode_shift = ~mode_select_low & ~mode_select_high;
    wire mode_two   =  mode_select_low & ~mode_select_high;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_control_register <= `SPB_RST_BYTE;
            power_control_register  <= `SPB_RST_BYTE;
            timer_mode_register     <= `SPB_RST_BYTE;
            timer_run_register      <= `SPB_RST_BYTE;
            timer2_control_register <= `SPB_RST_BYTE;
        end else begin
            if (wr_sctrl)  serial_control_register <= hwdata[7:0];
            if (wr_pctrl)  power_control_register  <= hwdata[7:0];
            if (wr_tmode)  timer_mode_register     <= hwdata[7:0];
            if (wr_trun)   timer_run_register      <= hwdata[7:0];
            if (wr_t2ctrl) timer2_control_register <= hwdata[7:0];
        end
    end

    // ---------------- timer 1
    wire [1:0] t1_mode = {timer_mode_register[`SPB_TM_M1], timer_mode_register[`SPB_TM_M0]};
    wire       t1_inc  = timer_run_register[`SPB_TR_RUN1] & (t1_mode != 2'b11) &
                         (timer_mode_register[`SPB_TM_CT] ? t1_fall : mc_tick);
    logic [7:0] t1_lo_nxt;
    logic [7:0] t1_hi_nxt;
    logic       t1_ovf;

    // mode 2 reloads the low byte from the reload byte
    always_comb begin
        t1_lo_nxt = timer1_count_low;
        t1_hi_nxt = timer1_reload_byte;
        t1_ovf    = 1'b0;
        if (t1_inc) begin
            unique case (t1_mode)
                2'b00: begin
                    t1_lo_nxt = {3'h0, 5'(timer1_count_low[4:0] + 5'h01)};
                    if (timer1_count_low[4:0] == 5'h1F) begin
                        t1_hi_nxt = timer1_reload_byte + 8'h01;
                        t1_ovf    = (timer1_reload_byte == 8'hFF);
                    end
                end
                2'b01: begin
                    t1_lo_nxt = timer1_count_low + 8'h01;
                    if (timer1_count_low == 8'hFF) begin
                        t1_hi_nxt = timer1_reload_byte + 8'h01;
                        t1_ovf    = (timer1_reload_byte == 8'hFF);
                    end
                end
                2'b10: begin
                    t1_lo_nxt = timer1_count_low + 8'h01;
                    if (timer1_count_low == 8'hFF) begin
                        t1_lo_nxt = timer1_reload_byte;
                        t1_ovf    = 1'b1;
                    end
                end
                2'b11: begin
                    t1_lo_nxt = timer1_count_low;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer1_count_low   <= `SPB_RST_BYTE;
            timer1_reload_byte <= `SPB_RST_BYTE;
        end else if (wr_t1cnt) begin
            timer1_count_low   <= hwdata[7:0];
            timer1_reload_byte <= hwdata[15:8];
        end else begin
            timer1_count_low   <= t1_lo_nxt;
            timer1_reload_byte <= t1_hi_nxt;
        end
    end

    // overflow divided by 32, or 16 when doubled
    logic [4:0] t1_div;
    wire  [4:0] t1_div_end = rate_double_bit ? `SPB_DIV_T1_DBL : `SPB_DIV_T1;
    wire        t1_bit     = t1_ovf & (t1_div == t1_div_end);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)    t1_div <= 5'h00;
        else if (t1_bit) t1_div <= 5'h00;
        else if (t1_ovf) t1_div <= t1_div + 5'h01;
    end

    // ---------------- timer 2
    // any clock select of either port enters generator mode
    wire gen_mode = rx_clock_select | tx_clock_select |
                    port2_rx_clock_select | port2_tx_clock_select;
    // generator timer operation counts every state time
    wire t2_inc   = timer2_run_bit &
                    (timer2_counter_select ? t2_fall : (gen_mode ? st_tick : mc_tick));
    wire t2_full  = ({timer2_count_high, timer2_count_low} == 16'hFFFF);
    wire t2_ovf   = t2_inc & t2_full;
    wire timer2_external_pin_hit = timer2_external_enable & timer2_external_pin_fall;
    // external edge reloads only outside generator mode
    wire t2_ext_reload = timer2_external_pin_hit & ~gen_mode & ~timer2_capture_mode;
    wire t2_capture    = timer2_external_pin_hit & ~gen_mode & timer2_capture_mode;
    wire t2_reload     = (t2_ovf & (gen_mode | ~timer2_capture_mode)) | t2_ext_reload;
    wire [15:0] t2_cnt_inc = {timer2_count_high, timer2_count_low} + 16'h0001;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer2_count_low  <= `SPB_RST_BYTE;
            timer2_count_high <= `SPB_RST_BYTE;
        end else if (wr_t2cnt) begin
            timer2_count_low  <= hwdata[7:0];
            timer2_count_high <= hwdata[15:8];
        end else if (t2_reload) begin
            timer2_count_low  <= timer2_reload_low;
            timer2_count_high <= timer2_reload_high;
        end else if (t2_inc) begin
            timer2_count_low  <= t2_cnt_inc[7:0];
            timer2_count_high <= t2_cnt_inc[15:8];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer2_reload_low  <= `SPB_RST_BYTE;
            timer2_reload_high <= `SPB_RST_BYTE;
        end else if (t2_capture) begin
            timer2_reload_low  <= timer2_count_low;
            timer2_reload_high <= timer2_count_high;
        end else if (wr_t2rld) begin
            timer2_reload_low  <= hwdata[7:0];
            timer2_reload_high <= hwdata[15:8];
        end
    end

    // hardware set wins over a software clear in the same cycle
    // generator rollover leaves the overflow flag alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer2_overflow_flag <= 1'b0;
            timer2_external_flag <= 1'b0;
            timer2_irq_flag      <= 1'b0;
        end else begin
            timer2_overflow_flag <= (t2_ovf & ~gen_mode) |
                (wr_t2ctrl ? hwdata[`SPB_T2_TF] : timer2_overflow_flag);
            // external edge still sets its flag
            timer2_external_flag <= timer2_external_pin_hit |
                (wr_t2ctrl ? hwdata[`SPB_T2_EXF] : timer2_external_flag);
            timer2_irq_flag      <= timer2_overflow_flag | timer2_external_flag;
        end
    end

    logic [3:0] t2_div;
    wire        t2_bit = t2_ovf & gen_mode & (t2_div == `SPB_DIV_T2);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)               t2_div <= 4'h0;
        else if (t2_ovf & gen_mode) t2_div <= t2_div + 4'h1;
    end

    // ---------------- mode 2 divider
    // oscillator over 64, or over 32 when doubled
    logic [5:0] m2_div;
    wire  [5:0] m2_end = rate_double_bit ? `SPB_DIV_M2_DBL : `SPB_DIV_M2;
    wire        m2_bit = (m2_div == m2_end);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)    m2_div <= 6'h00;
        else if (m2_bit) m2_div <= 6'h00;
        else             m2_div <= m2_div + 6'h01;
    end

    // ---------------- bit-rate ticks
    // shift mode runs once per machine cycle
    wire p1_fixed = mode_shift ? mc_tick : m2_bit;
    wire p1_fix_m = mode_shift | mode_two;
    // each direction picks timer 2 or timer 1
    wire p1_tx_n  = p1_fix_m ? p1_fixed : (tx_clock_select ? t2_bit : t1_bit);
    wire p1_rx_n  = p1_fix_m ? p1_fixed : (rx_clock_select ? t2_bit : t1_bit);
    wire p2_tx_n  = port2_tx_clock_select ? t2_bit : t1_bit;
    wire p2_rx_n  = port2_rx_clock_select ? t2_bit : t1_bit;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port1_tick <= '0;
            port2_tick <= '0;
        end else begin
            port1_tick <= '{tx: p1_tx_n, rx: p1_rx_n};
            port2_tick <= '{tx: p2_tx_n, rx: p2_rx_n};
        end
    end

    // ---------------- shift mode transmit
    spb_tx_e    tx_st;
    logic [8:0] tx_shift;
    wire        tx_mark = (tx_shift[8:1] == `SPB_TX_MARK);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_st    <= SPB_TX_IDLE;
            tx_shift <= 9'h000;
        end else if (wr_serial_buffer) begin
            // marker 1 in the ninth position
            tx_shift <= {1'b1, hwdata[7:0]};
            tx_st    <= mode_shift ? SPB_TX_ARM : SPB_TX_IDLE;
        end else if (!mode_shift) begin
            tx_st    <= SPB_TX_IDLE;
        end else begin
            unique case (tx_st)
                SPB_TX_IDLE: tx_st <= SPB_TX_IDLE;
                // send follows at the next S6P2 after the write
                SPB_TX_ARM:  if (mc_tick) tx_st <= SPB_TX_SEND;
                // shift right at S6P2, zeros from the left
                SPB_TX_SEND: if (mc_tick) begin
                    tx_shift <= {1'b0, tx_shift[8:1]};
                    if (tx_mark) tx_st <= SPB_TX_LAST;
                end
                SPB_TX_LAST: if (at_s1p1) tx_st <= SPB_TX_IDLE;
            endcase
        end
    end

    wire tx_done = mode_shift & (tx_st == SPB_TX_LAST) & at_s1p1;

    // ---------------- shift mode receive
    spb_rx_e    rx_st;
    logic [7:0] rx_shift;
    logic       rx_sample;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_st         <= SPB_RX_IDLE;
            rx_shift      <= 8'h00;
            rx_sample     <= 1'b1;
            serial_buffer <= `SPB_RST_BYTE;
        end else if (!mode_shift) begin
            rx_st <= SPB_RX_IDLE;
        end else begin
            // capture the data pin at S5P2
            if (at_s5p2) rx_sample <= rxd_sync;
            unique case (rx_st)
                // start on enable with receive flag clear
                SPB_RX_IDLE: if (rx_enable & ~receive_flag) rx_st <= SPB_RX_ARM;
                SPB_RX_ARM:  if (mc_tick) begin
                    rx_shift <= `SPB_RX_PRESET;
                    rx_st    <= SPB_RX_RECV;
                end
                // shift left, last shift loads the buffer
                SPB_RX_RECV: if (mc_tick) begin
                    rx_shift <= {rx_shift[6:0], rx_sample};
                    if (!rx_shift[7]) begin
                        // first bit received lands in bit 0
                        serial_buffer <= {rx_sample, rx_shift[0], rx_shift[1], rx_shift[2],
                                          rx_shift[3], rx_shift[4], rx_shift[5], rx_shift[6]};
                        rx_st         <= SPB_RX_DONE;
                    end
                end
                SPB_RX_DONE: if (at_s1p1) rx_st <= SPB_RX_IDLE;
            endcase
        end
    end

    wire rx_done = mode_shift & (rx_st == SPB_RX_DONE) & at_s1p1;

    // flags set at S1P1, set beats a software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transmit_flag <= 1'b0;
            receive_flag  <= 1'b0;
        end else begin
            transmit_flag <= tx_done |
                (wr_sctrl ? hwdata[`SPB_SC_TI] : transmit_flag);
            receive_flag  <= rx_done |
                (wr_sctrl ? hwdata[`SPB_SC_RI] : receive_flag);
        end
    end

    // ---------------- pins
    wire tx_active = (tx_st == SPB_TX_SEND) | (tx_st == SPB_TX_LAST);
    wire rx_active = (rx_st == SPB_RX_RECV) | (rx_st == SPB_RX_DONE);
    // clock low from S3P1 until S6P1
    wire sclk_nxt  = ~((ph_nxt >= `SPB_PH_S3P1) & (ph_nxt < `SPB_PH_S6P1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txd_out <= 1'b1;
            rxd_out <= 1'b1;
            rxd_oe  <= 1'b0;
        end else begin
            // clock on txd, data on rxd
            txd_out <= (mode_shift & (tx_active | rx_active)) ? sclk_nxt : 1'b1;
            rxd_out <= tx_shift[0];
            rxd_oe  <= mode_shift & tx_active;
        end
    end

    // ---------------- read data
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (ap_off)
            `SPB_OFF_SCTRL:  rd_word = {24'h0, serial_control_register[7:2],
                                        transmit_flag, receive_flag};
            `SPB_OFF_SERIAL_BUFFER:   rd_word = {24'h0, serial_buffer};
            `SPB_OFF_PCTRL:  rd_word = {24'h0, power_control_register};
            `SPB_OFF_TMODE:  rd_word = {24'h0, timer_mode_register};
            `SPB_OFF_TRUN:   rd_word = {24'h0, timer_run_register};
            `SPB_OFF_T1CNT:  rd_word = {16'h0, timer1_reload_byte, timer1_count_low};
            `SPB_OFF_T2CTRL: rd_word = {24'h0, timer2_overflow_flag, timer2_external_flag,
                                        timer2_control_register[5:0]};
            `SPB_OFF_T2CNT:  rd_word = {16'h0, timer2_count_high, timer2_count_low};
            `SPB_OFF_T2RLD:  rd_word = {16'h0, timer2_reload_high, timer2_reload_low};
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)                  hrdata <= 32'h0000_0000;
        else if (ap_valid & ~hwrite)   hrdata <= rd_word;
    end

endmodule : spb_serial_baud

// ---- verification/serial_port_baud_and_shift_mode_bench.sv ----
`timescale 1ns/1ps
module serial_port_baud_and_shift_mode_bench
    import spb_pkg::*;
;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, ext = 1'h1;
    logic        load = 1'h0, hreadyout, hresp, rxd_out, rxd_oe, txd_out, drv, irq;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [7:0]  src = 8'h00, got;
    spb_tick_s   p1, p2;
    int          fails = 0, samples_checked = 0, n;
    wire logic   line = rxd_oe ? rxd_out : drv;
    wire [3:0]   tk = {p2, p1};
    always #20 hclk = ~hclk;
    spb_serial_baud dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd_in(line), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .txd_out(txd_out), .t1_pin(1'h1), .t2_pin(1'h1),
        .timer2_external_pin(ext), .port1_tick(p1), .port2_tick(p2), .timer2_irq_flag(irq));
    spb_shift_peer peer_u (.hclk(hclk), .load(load), .src(src), .sclk(txd_out), .line(line),
        .drv(drv), .got(got));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'h1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask : xfer
    task automatic poll(input int b);
        n = 0;
        do begin
            xfer(8'h00, 1'h0, 32'h0);
            n++;
        end while (q[b] !== 1'h1 && n < 300);
    endtask : poll
    task automatic per(input int b);
        repeat (2) @(posedge hclk iff tk[b] === 1'h1);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (tk[b] !== 1'h1);
    endtask : per
    task automatic t_shift;
        xfer(8'h04, 1'h1, 32'hA5);
        poll(1);
        chk({31'h0, q[1]}, 32'h1);
        chk({24'h0, got}, 32'hA5);
        src  <= 8'h1E;
        load <= 1'h1;
        @(posedge hclk);
        load <= 1'h0;
        xfer(8'h00, 1'h1, 32'h10);
        poll(0);
        xfer(8'h04, 1'h0, 32'h0);
        chk(q, 32'h1E);
        xfer(8'h00, 1'h1, 32'h0);
    endtask : t_shift
    task automatic t_rates;
        per(1);
        chk(n, 32'hC);
        xfer(8'h00, 1'h1, 32'h80);
        per(1);
        chk(n, 32'h40);
        xfer(8'h08, 1'h1, 32'h80);
        per(1);
        chk(n, 32'h20);
        xfer(8'h00, 1'h1, 32'h40);
        // timer1 mode 2 auto-reload from reload byte 0xFF, no software reload
        xfer(8'h0C, 1'h1, 32'h20);
        xfer(8'h14, 1'h1, 32'hFF00);
        xfer(8'h10, 1'h1, 32'h1);
        per(1);
        chk(n, 32'hC0);
        xfer(8'h08, 1'h1, 32'h0);
        per(1);
        chk(n, 32'h180);
    endtask : t_rates
    task automatic t_gen;
        xfer(8'h08, 1'h1, 32'h80);
        // reload and count set before run
        xfer(8'h20, 1'h1, 32'hFFFE);
        xfer(8'h1C, 1'h1, 32'hFFFE);
        xfer(8'h18, 1'h1, 32'h14);
        per(1);
        chk(n, 32'h40);
        per(0);
        chk(n, 32'hC0);
        chk({31'h0, irq}, 32'h0);
        xfer(8'h08, 1'h1, 32'h82);
        xfer(8'h18, 1'h1, 32'h0C);
        per(3);
        chk(n, 32'h40);
        per(2);
        chk(n, 32'hC0);
        // stop timer 2 before touching its count
        xfer(8'h18, 1'h1, 32'h08);
        xfer(8'h1C, 1'h1, 32'h1234);
        ext <= 1'h0;
        repeat (8) @(posedge hclk);
        xfer(8'h1C, 1'h0, 32'h0);
        chk(q, 32'h1234);
        xfer(8'h18, 1'h0, 32'h0);
        chk(q, 32'h48);
        chk({31'h0, irq}, 32'h1);
        xfer(8'h1C, 1'h1, 32'hFFFE);
        xfer(8'h18, 1'h1, 32'h4C);
        per(3);
        chk(n, 32'h40);
    endtask : t_gen
    task automatic final_report;
        if (fails == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        t_shift;
        t_rates;
        t_gen;
        final_report;
    end
    initial begin
        #1000000;
        fails++;
        final_report;
    end
endmodule : serial_port_baud_and_shift_mode_bench

// ---- verification/spb_props_chk_props.sv ----
`timescale 1ns/1ps
module spb_props_chk
    import spb_pkg::*;
(
    // watched ports
    input wire logic      hclk,
    input wire logic      hresetn,
    input wire logic      rxd_out,
    input wire logic      rxd_oe,
    input wire logic      txd_out,
    input wire spb_tick_s port1_tick
);
    logic [7:0] oe_cnt;
    // length of a send, in clocks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            oe_cnt <= 8'h00;
        else
            oe_cnt <= rxd_oe ? oe_cnt + 8'h01 : 8'h00;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_low_span: assert property ($fell(txd_out) |-> !txd_out [*6] ##1 txd_out)
        else $error("shift clock low span wrong");
    chk_high_span: assert property ($rose(txd_out) |-> txd_out [*6])
        else $error("shift clock high span wrong");
    chk_clock_period: assert property ($fell(txd_out) |-> ##12 (txd_out || $fell(txd_out)))
        else $error("shift clock period wrong");
    chk_data_steady: assert property (rxd_oe && $past(rxd_oe) && $changed(rxd_out) |-> txd_out)
        else $error("data moved while clock low");
    chk_send_start: assert property ($rose(rxd_oe) |-> ##[3:6] $fell(txd_out))
        else $error("shift clock late after send");
    chk_oe_span: assert property ($fell(rxd_oe) |-> oe_cnt >= 8'h60 && oe_cnt <= 8'h62)
        else $error("send length wrong");
    chk_tx_tick: assert property (port1_tick.tx |=> !port1_tick.tx)
        else $error("tx tick too long");
    chk_rx_tick: assert property (port1_tick.rx |=> !port1_tick.rx)
        else $error("rx tick too long");
endmodule : spb_props_chk
bind spb_serial_baud spb_props_chk chk_u (.hclk(hclk), .hresetn(hresetn), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd_out), .port1_tick(port1_tick));

// ---- verification/spb_shift_peer.sv ----
`timescale 1ns/1ps
module spb_shift_peer (
    // control
    input  wire logic       hclk,
    input  wire logic       load,
    input  wire logic [7:0] src,
    // shift link
    input  wire logic       sclk,
    input  wire logic       line,
    output logic            drv,
    output logic [7:0]      got
);
    logic [7:0] sh;
    logic       sq;
    assign drv = sh[0];
    always @(posedge hclk) begin
        sq <= sclk;
        if (load)
            sh <= src;
        else if (sclk && !sq) begin
            got <= {line, got[7:1]};
            sh  <= {~sh[0], sh[7:1]};
        end
    end
endmodule : spb_shift_peer
